// File: verilog/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS  = 50;
   localparam int REF_MIN_NS     = 277000;
   localparam int REF_TYP_NS     = 544000;
   localparam int REF_MAX_NS     = 1075000;
   localparam int REF_MIN_CYCLES = (REF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REF_TYP_CYCLES = REF_TYP_NS / CLK_PERIOD_NS;
   localparam int REF_MAX_CYCLES = REF_MAX_NS / CLK_PERIOD_NS;
   localparam int PIN_LOW_MIN_NS = 2000;
   localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] WDT_HOLD_CYCLES = 3'h4;
   localparam int CNT_W = 21;

   // ==========================================================
   // addresses and fields
   localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
   localparam logic [15:0] VEC_HI_ADDR = 16'h0001;
   localparam logic [15:0] CAUSE_ADDR  = 16'hff54;
   localparam logic [15:0] PERIPH_BASE = 16'h0100;
   localparam int CAUSE_WDT_BIT = 4;
   localparam int CAUSE_LVI_BIT = 0;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // peripheral reset table
   localparam int NREG = 22;
   localparam int IDX_PSW        = 0;
   localparam int IDX_PORT_LATCH = 1;
   localparam int IDX_PORT_DIR   = 2;
   localparam int IDX_CPU_CLK    = 4;
   localparam int IDX_IRQ_MASK   = 11;
   localparam int IDX_VOLT_CTRL  = 17;
   localparam int IDX_VOLT_LEVEL = 18;
   localparam int IDX_FLASH_PROT = 19;

   typedef enum logic [1:0] {
      RSC_ALL       = 2'b00,
      RSC_KEEP_LVI  = 2'b01,
      RSC_UNDEFINED = 2'b10
   } rsc_kind_e;

   // psw, latch, dir, pullup, cpu_clk, presc, slow_osc, cmp_a, cmp_b, tmode,
   // irq_req, irq_mask, edge, fl_status, fl_cmd, fl_addr_cmp, fl_wbuf,
   // volt_ctrl, volt_level, fl_protect, fl_mode, fl_ptr
   localparam logic [7:0] REG_RST [NREG] = '{
      8'h02, 8'h00, 8'hff, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam rsc_kind_e REG_KIND [NREG] = '{
      RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL,
      RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL, RSC_ALL,
      RSC_ALL, RSC_KEEP_LVI, RSC_KEEP_LVI, RSC_UNDEFINED, RSC_UNDEFINED,
      RSC_UNDEFINED};

   typedef enum logic [2:0] {
      RSC_SQ_RESET    = 3'b000,
      RSC_SQ_WAIT     = 3'b001,
      RSC_SQ_FETCH_LO = 3'b010,
      RSC_SQ_FETCH_HI = 3'b011,
      RSC_SQ_LOAD     = 3'b100,
      RSC_SQ_RUN      = 3'b101
   } rsc_seq_e;
endpackage
`default_nettype wire

// File: verilog/rsc_seq_if.sv
`default_nettype none
interface rsc_seq_if;
   logic        int_reset;
   logic        cpu_halt;
   logic [15:0] pc;
   logic        pc_valid;
   logic [15:0] mem_addr;
   logic        mem_rd;
   logic [7:0]  mem_rdata;

   modport ctrl (output int_reset, mem_rdata,
                 input  cpu_halt, pc, pc_valid, mem_addr, mem_rd);
   modport seq  (input  int_reset, mem_rdata,
                 output cpu_halt, pc, pc_valid, mem_addr, mem_rd);
endinterface
`default_nettype wire

// File: verilog/rsc_sequencer.sv
`default_nettype none
module rsc_sequencer
   import rsc_pkg::*;
#(
   parameter int REF_CYCLES = REF_TYP_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   rsc_seq_if.seq   sq
);
   rsc_seq_e         state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [7:0]       lo_q;
   logic [15:0]      pc_q;
   logic             pc_valid_q;
   logic [15:0]      addr_q;
   logic             rd_q;
   logic             halt_q;

   // ==========================================================
   // state
   always_ff @(posedge clock) begin
      if (rst || sq.int_reset) begin
         state_q <= RSC_SQ_RESET;
      end else begin
         case (state_q)
            RSC_SQ_RESET:    state_q <= RSC_SQ_WAIT;
            RSC_SQ_WAIT: begin
               if (cnt_q == CNT_W'(REF_CYCLES - 1)) begin
                  state_q <= RSC_SQ_FETCH_LO;
               end
            end
            RSC_SQ_FETCH_LO: state_q <= RSC_SQ_FETCH_HI;
            RSC_SQ_FETCH_HI: state_q <= RSC_SQ_LOAD;
            RSC_SQ_LOAD:     state_q <= RSC_SQ_RUN;
            RSC_SQ_RUN:      state_q <= RSC_SQ_RUN;
            default:         state_q <= RSC_SQ_RESET;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (state_q != RSC_SQ_WAIT) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // ==========================================================
   // vector fetch, one cycle read latency
   always_ff @(posedge clock) begin
      if (rst) begin
         addr_q <= VEC_LO_ADDR;
         rd_q   <= 1'b0;
      end else begin
         rd_q   <= (state_q == RSC_SQ_FETCH_LO) || (state_q == RSC_SQ_FETCH_HI);
         addr_q <= (state_q == RSC_SQ_FETCH_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         lo_q       <= 8'h00;
         pc_q       <= 16'h0000;
         pc_valid_q <= 1'b0;
      end else begin
         if (state_q == RSC_SQ_FETCH_HI) begin
            lo_q <= sq.mem_rdata;
         end
         if (state_q == RSC_SQ_LOAD) begin
            pc_q <= {sq.mem_rdata, lo_q};
         end
         // pc is the only thing not trustworthy until the load
         pc_valid_q <= !sq.int_reset && ((state_q == RSC_SQ_LOAD) || pc_valid_q);
      end
   end

   always_ff @(posedge clock) begin
      if (rst || sq.int_reset) begin
         halt_q <= 1'b1;
      end else begin
         halt_q <= (state_q != RSC_SQ_LOAD) && (state_q != RSC_SQ_RUN);
      end
   end

   assign sq.cpu_halt = halt_q;
   assign sq.pc       = pc_q;
   assign sq.pc_valid = pc_valid_q;
   assign sq.mem_addr = addr_q;
   assign sq.mem_rd   = rd_q;

   // ==========================================================
   // checks
   sequence s_fetch;
      (state_q == RSC_SQ_FETCH_HI) ##1 (state_q == RSC_SQ_LOAD) ##1 (state_q == RSC_SQ_RUN);
   endsequence

   property p_fetch_order;
      @(posedge clock) disable iff (rst || sq.int_reset)
         (state_q == RSC_SQ_FETCH_LO) |=> s_fetch;
   endproperty

   chk_fetch_order: assert property (p_fetch_order)
      else $error("vector fetch out of order");

   chk_pc_from_vector: assert property (
      @(posedge clock) disable iff (rst || sq.int_reset)
         (state_q == RSC_SQ_LOAD) |=> (pc_q == {$past(sq.mem_rdata), lo_q}) && pc_valid_q)
      else $error("pc not loaded from vector");
endmodule
`default_nettype wire

// File: verilog/rsc_top.sv
`default_nettype none
module rsc_top
   import rsc_pkg::*;
#(
   parameter int REF_CYCLES = REF_TYP_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              reset_pin_n,
   input  wire logic              watchdog_overflow,
   input  wire logic              power_on_clear,
   input  wire logic              low_voltage_detector,
   output logic                   int_reset_q,
   output logic                   wdt_timer_reset_q,
   output logic                   cpu_halt_q,
   output logic [15:0]            pc_q,
   output logic                   pc_valid_q,
   output logic [15:0]            mem_addr_q,
   output logic                   mem_rd_q,
   input  wire logic [7:0]        mem_rdata,
   output logic [NREG*8-1:0]      periph_q,
   input  wire logic [15:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [15:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   rsc_seq_if sq ();

   // ==========================================================
   // source merge
   logic [2:0] wdt_hold_q;
   logic       hard_src;
   logic       any_src;
   logic       hard_q;

   // watchdog request is a pulse; stretch it so the release comes by itself
   always_ff @(posedge clock) begin
      if (rst) begin
         wdt_hold_q <= 3'h0;
      end else if (watchdog_overflow) begin
         wdt_hold_q <= WDT_HOLD_CYCLES;
      end else if (wdt_hold_q != 3'h0) begin
         wdt_hold_q <= wdt_hold_q - 3'h1;
      end
   end

   // pin is taken as a level; its 2 us minimum low time is the driver's job
   assign hard_src = !reset_pin_n || power_on_clear || watchdog_overflow
                     || (wdt_hold_q != 3'h0);
   assign any_src  = hard_src || low_voltage_detector;

   always_ff @(posedge clock) begin
      if (rst) begin
         int_reset_q <= 1'b1;
         hard_q      <= 1'b1;
      end else begin
         int_reset_q <= any_src;
         hard_q      <= hard_src;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wdt_timer_reset_q <= 1'b1;
      end else begin
         wdt_timer_reset_q <= any_src;
      end
   end

   assign sq.int_reset = int_reset_q;
   assign sq.mem_rdata = mem_rdata;
   assign cpu_halt_q   = sq.cpu_halt;
   assign pc_q         = sq.pc;
   assign pc_valid_q   = sq.pc_valid;
   assign mem_addr_q   = sq.mem_addr;
   assign mem_rd_q     = sq.mem_rd;

   rsc_sequencer #(
      .REF_CYCLES (REF_CYCLES)
   ) u_seq (
      .clock (clock),
      .rst   (rst),
      .sq    (sq)
   );

   // ==========================================================
   // register bus
   logic        aw_held_q;
   logic        w_held_q;
   logic [15:0] awaddr_q;
   logic [7:0]  wbyte_q;
   logic        wlane_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        rd_cause_q;
   logic        wr_fire;
   logic        ar_fire;
   logic        rd_clear;
   logic        wr_hit;
   logic [4:0]  wr_idx;
   logic        rd_hit;
   logic [4:0]  rd_idx;
   logic [7:0]  regs_q [NREG];
   logic [1:0]  cause_q;
   logic        awready_q;
   logic        wready_q;

   function automatic logic decode(input logic [15:0] a, output logic [4:0] idx);
      logic [15:0] off;
      off = a - PERIPH_BASE;
      idx = off[6:2];
      return (a >= PERIPH_BASE) && (off[15:2] < 14'(NREG)) && (a[1:0] == 2'b00);
   endfunction

   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign ar_fire = s_axi_arvalid && arready_q;

   always_comb begin
      wr_idx = 5'h00;
      rd_idx = 5'h00;
      wr_hit = decode(awaddr_q, wr_idx);
      rd_hit = decode(s_axi_araddr, rd_idx);
   end

   // address and data may come in either order; both wait for the response
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 16'h0000;
         wbyte_q   <= 8'h00;
         wlane_q   <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // ready kept in its own flop so the port is a register
   always_ff @(posedge clock) begin
      if (rst) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end else begin
         awready_q <= aw_held_q ? wr_fire : !s_axi_awvalid;
         wready_q  <= w_held_q ? wr_fire : !s_axi_wvalid;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         arready_q  <= 1'b1;
         rvalid_q   <= 1'b0;
         rdata_q    <= 32'h0000_0000;
         rresp_q    <= RESP_OKAY;
         rd_cause_q <= 1'b0;
      end else if (ar_fire) begin
         arready_q  <= 1'b0;
         rvalid_q   <= 1'b1;
         rd_cause_q <= (s_axi_araddr == CAUSE_ADDR);
         if (s_axi_araddr == CAUSE_ADDR) begin
            rdata_q <= 32'h0000_0000;
            rdata_q[CAUSE_WDT_BIT] <= cause_q[1];
            rdata_q[CAUSE_LVI_BIT] <= cause_q[0];
            rresp_q <= RESP_OKAY;
         end else if (rd_hit) begin
            rdata_q <= {24'h00_0000, regs_q[rd_idx]};
            rresp_q <= RESP_OKAY;
         end else begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ==========================================================
   // reset cause flags: [1] watchdog, [0] undervoltage
   assign rd_clear = ar_fire && (s_axi_araddr == CAUSE_ADDR);

   // a set in the same cycle as the read clear survives
   always_ff @(posedge clock) begin
      if (rst || !reset_pin_n || power_on_clear) begin
         cause_q <= 2'b00;
      end else begin
         cause_q[1] <= watchdog_overflow || (cause_q[1] && !rd_clear);
         cause_q[0] <= low_voltage_detector || (cause_q[0] && !rd_clear);
      end
   end

   // ==========================================================
   // peripheral reset values; cpu writes blocked while held
   // ram and general registers are elsewhere and are never touched here
   genvar g;
   for (g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge clock) begin
         if (rst) begin
            regs_q[g] <= REG_RST[g];
         end else if (int_reset_q && (REG_KIND[g] == RSC_ALL)) begin
            regs_q[g] <= REG_RST[g];
         end else if (int_reset_q && hard_q && (REG_KIND[g] == RSC_KEEP_LVI)) begin
            regs_q[g] <= REG_RST[g];
         end else if (wr_fire && wr_hit && wlane_q && !int_reset_q && (wr_idx == 5'(g))) begin
            regs_q[g] <= wbyte_q;
         end
      end
      assign periph_q[g*8 +: 8] = regs_q[g];
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_halt_after_release: assert property (
      $fell(int_reset_q) |-> cpu_halt_q [*8])
      else $error("cpu runs too soon after reset release");

   chk_wdt_timer_reset: assert property (
      watchdog_overflow |=> wdt_timer_reset_q ##1 int_reset_q)
      else $error("watchdog timer not reset");

   chk_psw_value: assert property (
      int_reset_q |=> (regs_q[IDX_PSW] == REG_RST[IDX_PSW]))
      else $error("status word not at reset value");

   chk_port_dir_mask: assert property (
      int_reset_q |=> (regs_q[IDX_PORT_DIR] == 8'hff) && (regs_q[IDX_IRQ_MASK] == 8'hff))
      else $error("direction or mask not all ones");

   chk_cause_spare_bits: assert property (
      (rvalid_q && rd_cause_q) |-> (rdata_q[7:5] == 3'b000) && (rdata_q[3:1] == 3'b000))
      else $error("spare cause bits not zero");

   chk_read_clears: assert property (
      (rd_clear && reset_pin_n && !watchdog_overflow && !low_voltage_detector)
         |=> (cause_q == 2'b00))
      else $error("cause read did not clear");

   chk_pin_clears_flags: assert property (
      (!reset_pin_n || power_on_clear) |=> (cause_q == 2'b00))
      else $error("pin or power-on reset left a flag");

   chk_wdt_flag_set: assert property (
      (watchdog_overflow && reset_pin_n && !power_on_clear && !rd_clear && !low_voltage_detector)
         |=> cause_q[1] && (cause_q[0] == $past(cause_q[0])))
      else $error("watchdog flag wrong");

   chk_lvi_flag_set: assert property (
      (low_voltage_detector && reset_pin_n && !power_on_clear && !watchdog_overflow)
         |=> cause_q[0])
      else $error("undervoltage flag not set");

   chk_lvi_keeps_volt: assert property (
      (int_reset_q && !hard_q) |=> $stable(regs_q[IDX_VOLT_CTRL])
         && $stable(regs_q[IDX_VOLT_LEVEL]))
      else $error("voltage registers changed on undervoltage reset");

   chk_release_sync: assert property (
      (!any_src && int_reset_q) |=> !int_reset_q)
      else $error("internal reset release late");

   // quiet sources after the pulse
   sequence s_no_source;
      reset_pin_n && !watchdog_overflow && !power_on_clear && !low_voltage_detector;
   endsequence

   chk_wdt_self_release: assert property (
      watchdog_overflow ##1 s_no_source [*5] |=> !int_reset_q)
      else $error("watchdog reset did not release");

   // halted cycles since the internal reset fell
   logic [CNT_W-1:0] held_cnt_q;

   always_ff @(posedge clock) begin
      if (rst || int_reset_q) begin
         held_cnt_q <= '0;
      end else if (cpu_halt_q) begin
         held_cnt_q <= held_cnt_q + CNT_W'(1);
      end
   end

   chk_halt_length: assert property (
      $fell(cpu_halt_q) |-> (held_cnt_q == CNT_W'(REF_CYCLES + 4)))
      else $error("halt length after release wrong");
endmodule
`default_nettype wire

// File: tb/rsc_src_model.sv
`default_nettype none
module rsc_src_model
   import rsc_pkg::*;
#(
   parameter logic [7:0] VEC_LO = 8'h3c,
   parameter logic [7:0] VEC_HI = 8'h12
) (
   input  wire logic        clock,
   input  wire logic        src_req,
   input  wire logic [1:0]  src_kind,
   output logic             reset_pin_n,
   output logic             watchdog_overflow,
   output logic             power_on_clear,
   output logic             low_voltage_detector,
   input  wire logic        mem_rd_q,
   input  wire logic [15:0] mem_addr_q,
   output logic [7:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q = 8'h00;
   logic [1:0] kind_q = 2'h0;
   logic [7:0] last_q = 8'h00;
   initial watchdog_overflow = 1'b0;
   // ==========================================================
   // reset sources: 0 pin, 1 watchdog, 2 power-on clear, 3 low voltage
   always @(posedge clock) begin
      watchdog_overflow <= 1'b0;
      if (src_req) begin
         kind_q <= src_kind;
         cnt_q <= (src_kind == 2'h0) ? PIN_LOW_CYCLES[7:0] : 8'h06;
         watchdog_overflow <= (src_kind == 2'h1);
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
      if (mem_rd_q) begin
         last_q <= mem_rdata;
      end
   end
   assign reset_pin_n = !(cnt_q != 8'h00 && kind_q == 2'h0);
   assign power_on_clear = (cnt_q != 8'h00 && kind_q == 2'h2);
   assign low_voltage_detector = (cnt_q != 8'h00 && kind_q == 2'h3);
   // ==========================================================
   // vector memory; idle bus shows the inverse so a stale byte never matches
   always_comb begin
      mem_rdata = ~last_q;
      if (mem_rd_q && mem_addr_q == VEC_LO_ADDR) mem_rdata = VEC_LO;
      if (mem_rd_q && mem_addr_q == VEC_HI_ADDR) mem_rdata = VEC_HI;
   end
endmodule
`default_nettype wire

// File: tb/reset_source_controller_tb.sv
`default_nettype none
module reset_source_controller_tb
   import rsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int REF = 16;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic [1:0]  resp;
   } rsc_row_s;
   // ==========================================================
   // reset image: 22 peripheral bytes, cause register, an unmapped word
   localparam rsc_row_s ROWS [24] = '{
      '{16'h0100, 8'h02, 2'b00}, '{16'h0104, 8'h00, 2'b00}, '{16'h0108, 8'hff, 2'b00},
      '{16'h010c, 8'h00, 2'b00}, '{16'h0110, 8'h02, 2'b00}, '{16'h0114, 8'h02, 2'b00},
      '{16'h0118, 8'h00, 2'b00}, '{16'h011c, 8'h00, 2'b00}, '{16'h0120, 8'h00, 2'b00},
      '{16'h0124, 8'h00, 2'b00}, '{16'h0128, 8'h00, 2'b00}, '{16'h012c, 8'hff, 2'b00},
      '{16'h0130, 8'h00, 2'b00}, '{16'h0134, 8'h00, 2'b00}, '{16'h0138, 8'h00, 2'b00},
      '{16'h013c, 8'h00, 2'b00}, '{16'h0140, 8'h00, 2'b00}, '{16'h0144, 8'h00, 2'b00},
      '{16'h0148, 8'h00, 2'b00}, '{16'h014c, 8'h00, 2'b00}, '{16'h0150, 8'h00, 2'b00},
      '{16'h0154, 8'h00, 2'b00}, '{16'hff54, 8'h00, 2'b00}, '{16'h0200, 8'h00, 2'b10}};
   logic        clock, rst, reset_pin_n, watchdog_overflow, power_on_clear;
   logic        low_voltage_detector, int_reset_q, wdt_timer_reset_q, cpu_halt_q;
   logic        pc_valid_q, mem_rd_q, src_req;
   logic [1:0]  src_kind, s_axi_bresp, s_axi_rresp, r;
   logic [15:0] pc_q, mem_addr_q, s_axi_awaddr, s_axi_araddr;
   logic [7:0]  mem_rdata;
   logic [NREG*8-1:0] periph_q;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc = 0;

   rsc_top #(.REF_CYCLES(REF)) i_rsc_top (
      .clock(clock), .rst(rst), .reset_pin_n(reset_pin_n),
      .watchdog_overflow(watchdog_overflow), .power_on_clear(power_on_clear),
      .low_voltage_detector(low_voltage_detector), .int_reset_q(int_reset_q),
      .wdt_timer_reset_q(wdt_timer_reset_q), .cpu_halt_q(cpu_halt_q), .pc_q(pc_q),
      .pc_valid_q(pc_valid_q), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
      .mem_rdata(mem_rdata), .periph_q(periph_q), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   rsc_src_model i_rsc_src_model (
      .clock(clock), .src_req(src_req), .src_kind(src_kind), .reset_pin_n(reset_pin_n),
      .watchdog_overflow(watchdog_overflow), .power_on_clear(power_on_clear),
      .low_voltage_detector(low_voltage_detector), .mem_rd_q(mem_rd_q),
      .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic final_report();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ==========================================================
   // bus master; only the run limit ends a wait
   task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] rs);
      int t;
      logic a_ok, w_ok;
      t = 0;
      a_ok = 1'b0;
      w_ok = 1'b0;
      rs = 2'bxx;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (t == 0) begin
         @(posedge clock);
         if (a_ok && w_ok && s_axi_bvalid === 1'b1) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            t = 1000;
         end
         if (!a_ok && s_axi_awready === 1'b1) begin
            a_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rs);
      int t;
      logic took;
      t = 0;
      took = 1'b0;
      d = 'x;
      rs = 2'bxx;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (t == 0) begin
         @(posedge clock);
         if (took && s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            t = 1000;
         end
         if (!took && s_axi_arready === 1'b1) begin
            took = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  rs;
      axi_rd(a, d, rs);
      chk("read data", {24'h00_0000, e}, d);
      chk("read resp", {30'h0000_0000, er}, {30'h0000_0000, rs});
   endtask

   // count from internal reset release to cpu run
   task automatic wait_run();
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (int_reset_q !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      while (int_reset_q === 1'b1 && n < 500) begin
         @(negedge clock);
         seen = seen | wdt_timer_reset_q;
         n++;
      end
      chk("wdt reset seen", 32'h0000_0001, {31'h0000_0000, seen});
      chk("pc valid in wait", 32'h0000_0000, {31'h0000_0000, pc_valid_q});
      n = 0;
      while (cpu_halt_q === 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      chk("halt cycles", REF + 4, n);
   endtask

   task automatic do_reset(input logic [1:0] k);
      @(posedge clock);
      src_kind <= k;
      src_req <= 1'b1;
      @(posedge clock);
      src_req <= 1'b0;
      wait_run();
   endtask

   task automatic check_rows();
      for (int i = 0; i < 24; i++) begin
         rd_chk(ROWS[i].addr, ROWS[i].data, ROWS[i].resp);
         if (i < NREG) chk("periph byte", {24'h00_0000, ROWS[i].data}, {24'h00_0000, periph_q[8*i +: 8]});
      end
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("unexpected run length expected %0d seen %0d", 19999, cyc);
         final_report();
      end
   end

   initial begin
      rst = 1'b1;
      src_req = 1'b0;
      src_kind = 2'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 16'h0000;
      s_axi_araddr = 16'h0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      wait_run();
      chk("pc", 32'h0000_123c, {16'h0000, pc_q});
      chk("pc valid", 32'h0000_0001, {31'h0000_0000, pc_valid_q});
      check_rows();
      for (int i = 0; i < 19; i++) begin
         axi_wr(16'h0100 + 16'(4 * i), 8'ha5, r);
         chk("write resp", 32'h0000_0000, {30'h0000_0000, r});
      end
      rd_chk(16'h0100, 8'ha5, 2'b00);
      do_reset(2'h0);
      check_rows();
      axi_wr(16'h0144, 8'h81, r);
      axi_wr(16'h0100, 8'h77, r);
      do_reset(2'h3);
      rd_chk(16'h0144, 8'h81, 2'b00);
      rd_chk(16'h0100, 8'h02, 2'b00);
      do_reset(2'h1);
      rd_chk(16'hff54, 8'h11, 2'b00);
      rd_chk(16'hff54, 8'h00, 2'b00);
      rd_chk(16'h0144, 8'h00, 2'b00);
      do_reset(2'h1);
      do_reset(2'h2);
      rd_chk(16'hff54, 8'h00, 2'b00);
      do_reset(2'h3);
      do_reset(2'h0);
      rd_chk(16'hff54, 8'h00, 2'b00);
      do_reset(2'h3);
      axi_wr(16'hff54, 8'hff, r);
      chk("cause write resp", 32'h0000_0002, {30'h0000_0000, r});
      rd_chk(16'hff54, 8'h01, 2'b00);
      axi_wr(16'h0200, 8'h11, r);
      chk("unmapped write resp", 32'h0000_0002, {30'h0000_0000, r});
      final_report();
   end
endmodule
`default_nettype wire
